// [include/sref_delay_map.svh]
//
// Contract
// - Inversion control set inverts the sampling clock, adding half a period.
// - Coarse and fine delay settings each have 256 steps.
// - Inversion, coarse and fine act independently and combine together.
// - Delay shifts every internal clock, including serial output and capture.
// - Delay settings may change during operation; the link may glitch.
// - With ramp active, effective coarse steps gradually toward the new value.
// - Ramp rate: slow one step per 256 cycles, fast four per 384.
// - With ramp enabled, every coarse write starts a new ramp.
// - Single-channel mode samples on both edges, doubling the capture window.
// - Device finds where the reference falls and stores the position map.
// - Position map is valid only after three reference rising edges.
// - Each map bit is one position; 1 means setup or hold risk.
// - Reference is captured at the position whose index equals the select.
// - Refine control gives coarse position steps at 0, fine at 1.
// - Map bits 0 and 23 always read 1.
// - Map reports 24 positions; select addresses only the first 16.
// - Reference is captured on a deterministic clock edge every time.
`ifndef SREF_DELAY_MAP_SVH
`define SREF_DELAY_MAP_SVH

// Register byte offsets
`define OFS_DELAY_CTRL 4'h0
`define OFS_SREF_CTRL 4'h4
`define OFS_STATUS 4'h8
`define OFS_POS_MAP 4'hc

// Delay control fields
`define F_INVERT 0
`define F_COARSE_LO 8
`define F_COARSE_HI 15
`define F_FINE_LO 16
`define F_FINE_HI 23
`define F_RAMP_EN 24
`define F_RAMP_FAST 25

// Reference control fields
`define F_SEL_LO 0
`define F_SEL_HI 3
`define F_REFINE 4
`define F_SINGLE_CH 5

// Status fields
`define F_STAT_RAMPING 8
`define F_STAT_VALID 9

// Ramp timing in clock cycles
`define RAMP_SLOW_PERIOD 9'h100
`define RAMP_FAST_PERIOD 9'h060
`define RAMP_CNT_ONE 9'h001

// Reference detector
`define POS_ENDS 24'h800001
`define POS_MID 12
`define EDGES_NEEDED 2'h3
`define EDGE_ONE 2'h1

// Reset values and the HTRANS non-sequential bit
`define RST_BYTE 8'h00
`define RST_SEL 4'h0
`define RST_WORD 32'h00000000
`define HTRANS_NONSEQ_BIT 1

`endif

// [include/sref_delay_pkg.sv]
package sref_delay_pkg;

  // AHB-Lite request from the master
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  // AHB-Lite response to the master
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  // Controls toward the analog delay cells and capture path
  typedef struct packed {
    logic invert;
    logic [7:0] coarse;
    logic [7:0] fine;
    logic dual_edge;
    logic refine;
    logic sref_captured;
  } clk_ctrl_t;

  // Coarse ramp sequencer
  typedef enum logic {
    RAMP_IDLE,
    RAMP_RUN
  } ramp_state_t;

  // Whole state of the block
  typedef struct packed {
    logic hready;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [3:0] wr_ofs;
    logic invert;
    logic [7:0] target;
    logic [7:0] fine;
    logic ramp_en;
    logic ramp_fast;
    logic [3:0] sel;
    logic refine;
    logic single_ch;
    ramp_state_t ramp;
    logic [7:0] eff;
    logic [8:0] ramp_cnt;
    logic [23:0] sync1;
    logic [23:0] sync2;
    logic prev_mid;
    logic [1:0] edge_cnt;
    logic [23:0] map;
    logic captured;
  } state_t;

endpackage

// [design/sampling_delay_and_sysref_window.sv]
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sref_delay_map.svh"

module sampling_delay_and_sysref_window
  import sref_delay_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave port
  input wire ahb_req_t ahb_i,
  output var ahb_rsp_t ahb_o,
  // Reference sampled through the delayed position taps
  input wire logic [23:0] sref_taps,
  // Controls to the clock path
  output var clk_ctrl_t clk_o
);

  state_t st_reg;
  state_t st_next;
  logic [23:0] viol;
  logic addr_take;
  logic wr_delay;
  logic wr_sref;
  logic wr_map;
  logic ramp_step;
  logic [8:0] ramp_period;

  // Word select from a byte offset
  function automatic logic hit(input logic [3:0] ofs, input logic [3:0] reg_ofs);
    hit = (ofs == reg_ofs);
  endfunction

  // Violation risk around an edge found between neighbouring taps
  generate
    for (genvar i = 0; i < 24; i++) begin : g_viol
      if (i == 0 || i == 23) begin : g_end
        assign viol[i] = 1'b1;
      end else begin : g_mid
        assign viol[i] = (st_reg.sync2[i] ^ st_reg.sync2[i-1]) |
                         (st_reg.sync2[i] ^ st_reg.sync2[i+1]);
      end
    end
  endgenerate

  // Bus decode and ramp timing
  assign addr_take = ahb_i.hsel & ahb_i.hready &
                     ahb_i.htrans[`HTRANS_NONSEQ_BIT];
  assign wr_delay = st_reg.wr_pend & hit(st_reg.wr_ofs, `OFS_DELAY_CTRL);
  assign wr_sref = st_reg.wr_pend & hit(st_reg.wr_ofs, `OFS_SREF_CTRL);
  assign wr_map = st_reg.wr_pend & hit(st_reg.wr_ofs, `OFS_POS_MAP);
  assign ramp_period = st_reg.ramp_fast ? `RAMP_FAST_PERIOD
                                        : `RAMP_SLOW_PERIOD;
  assign ramp_step = (st_reg.ramp_cnt == ramp_period);

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.hready = 1'b1;
    // Address phase: latch write target, prepare read data
    st_next.wr_pend = addr_take & ahb_i.hwrite;
    st_next.wr_ofs = ahb_i.haddr[3:0];
    st_next.hrdata = `RST_WORD;
    if (addr_take && !ahb_i.hwrite) begin
      if (hit(ahb_i.haddr[3:0], `OFS_DELAY_CTRL)) begin
        st_next.hrdata[`F_INVERT] = st_reg.invert;
        st_next.hrdata[`F_COARSE_HI:`F_COARSE_LO] = st_reg.target;
        st_next.hrdata[`F_FINE_HI:`F_FINE_LO] = st_reg.fine;
        st_next.hrdata[`F_RAMP_EN] = st_reg.ramp_en;
        st_next.hrdata[`F_RAMP_FAST] = st_reg.ramp_fast;
      end else if (hit(ahb_i.haddr[3:0], `OFS_SREF_CTRL)) begin
        st_next.hrdata[`F_SEL_HI:`F_SEL_LO] = st_reg.sel;
        st_next.hrdata[`F_REFINE] = st_reg.refine;
        st_next.hrdata[`F_SINGLE_CH] = st_reg.single_ch;
      end else if (hit(ahb_i.haddr[3:0], `OFS_STATUS)) begin
        st_next.hrdata[7:0] = st_reg.eff;
        st_next.hrdata[`F_STAT_RAMPING] = (st_reg.ramp == RAMP_RUN);
        st_next.hrdata[`F_STAT_VALID] =
          (st_reg.edge_cnt == `EDGES_NEEDED);
      end else if (hit(ahb_i.haddr[3:0], `OFS_POS_MAP)) begin
        st_next.hrdata[23:0] = st_reg.map;
      end
    end
    // Data phase writes; taken at any time in operation
    if (wr_delay) begin
      st_next.invert = ahb_i.hwdata[`F_INVERT];
      st_next.target = ahb_i.hwdata[`F_COARSE_HI:`F_COARSE_LO];
      st_next.fine = ahb_i.hwdata[`F_FINE_HI:`F_FINE_LO];
      st_next.ramp_en = ahb_i.hwdata[`F_RAMP_EN];
      st_next.ramp_fast = ahb_i.hwdata[`F_RAMP_FAST];
    end
    if (wr_sref) begin
      st_next.sel = ahb_i.hwdata[`F_SEL_HI:`F_SEL_LO];
      st_next.refine = ahb_i.hwdata[`F_REFINE];
      st_next.single_ch = ahb_i.hwdata[`F_SINGLE_CH];
    end
    // Coarse ramp sequencer
    st_next.ramp_cnt = st_reg.ramp_cnt + `RAMP_CNT_ONE;
    case (st_reg.ramp)
      RAMP_IDLE: begin
        st_next.eff = st_reg.target;
        st_next.ramp_cnt = `RAMP_CNT_ONE;
      end
      RAMP_RUN: begin
        if (!st_reg.ramp_en) begin
          st_next.eff = st_reg.target;
          st_next.ramp = RAMP_IDLE;
        end else if (st_reg.eff == st_reg.target) begin
          st_next.ramp = RAMP_IDLE;
        end else if (ramp_step) begin
          st_next.ramp_cnt = `RAMP_CNT_ONE;
          if (st_reg.eff < st_reg.target) begin
            st_next.eff = st_reg.eff + 8'h01;
          end else begin
            st_next.eff = st_reg.eff - 8'h01;
          end
        end
      end
      default: begin
        st_next.ramp = RAMP_IDLE;
      end
    endcase
    // A coarse write restarts or bypasses the ramp
    if (wr_delay) begin
      if (ahb_i.hwdata[`F_RAMP_EN]) begin
        st_next.ramp = RAMP_RUN;
        st_next.ramp_cnt = `RAMP_CNT_ONE;
        st_next.eff = (st_reg.ramp == RAMP_IDLE) ? st_reg.target
                                                 : st_reg.eff;
      end else begin
        st_next.ramp = RAMP_IDLE;
        st_next.eff = ahb_i.hwdata[`F_COARSE_HI:`F_COARSE_LO];
      end
    end
    // Two-stage synchronisers on every tap
    st_next.sync1 = sref_taps;
    st_next.sync2 = st_reg.sync1;
    st_next.prev_mid = st_reg.sync2[`POS_MID];
    // Count reference rising edges, saturating
    st_next.edge_cnt = st_reg.edge_cnt;
    if (st_reg.sync2[`POS_MID] && !st_reg.prev_mid &&
        st_reg.edge_cnt != `EDGES_NEEDED) begin
      st_next.edge_cnt = st_reg.edge_cnt + `EDGE_ONE;
    end
    // Sticky position map; a clear write loses to a new flag
    st_next.map = (wr_map ? `POS_ENDS : st_reg.map) | viol;
    if (wr_map) begin
      st_next.edge_cnt = 2'h0;
    end
    // Fixed tap on a fixed edge keeps capture deterministic
    st_next.captured = st_reg.sync2[st_reg.sel];
    if (sys_rst) begin
      st_next = '0;
      st_next.hready = 1'b1;
      st_next.ramp = RAMP_IDLE;
      st_next.sel = `RST_SEL;
      st_next.target = `RST_BYTE;
      st_next.eff = `RST_BYTE;
      st_next.map = `POS_ENDS;
      st_next.ramp_cnt = `RAMP_CNT_ONE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // Bus response
  assign ahb_o.hreadyout = st_reg.hready;
  assign ahb_o.hresp = 1'b0;
  assign ahb_o.hrdata = st_reg.hrdata;

  // Clock path controls, invert and fine applied at once, coarse through the ramp; the analog path
  // shifts every internal clock and the capture taps by this amount
  assign clk_o.invert = st_reg.invert;
  assign clk_o.coarse = st_reg.eff;
  assign clk_o.fine = st_reg.fine;
  assign clk_o.dual_edge = st_reg.single_ch;
  assign clk_o.refine = st_reg.refine;
  assign clk_o.sref_captured = st_reg.captured;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_coarse_write_ramp;
    wr_delay && ahb_i.hwdata[`F_RAMP_EN];
  endsequence

  sequence s_coarse_write_direct;
    wr_delay && !ahb_i.hwdata[`F_RAMP_EN];
  endsequence

  a_bus_always_ok: assert property (
    ahb_o.hreadyout && !ahb_o.hresp)
    else $error("slave not ready or error response");

  a_invert_write: assert property (
    wr_delay |=> clk_o.invert == $past(ahb_i.hwdata[`F_INVERT]))
    else $error("inversion did not follow write");

  a_direct_coarse: assert property (
    s_coarse_write_direct |=>
      clk_o.coarse == $past(ahb_i.hwdata[`F_COARSE_HI:`F_COARSE_LO]))
    else $error("direct coarse write not applied");

  a_ramp_starts: assert property (
    s_coarse_write_ramp |=> st_reg.ramp == RAMP_RUN)
    else $error("coarse write did not start a ramp");

  a_ramp_single_step: assert property (
    st_reg.ramp == RAMP_RUN && st_reg.ramp_en && !wr_delay &&
    $past(st_reg.ramp) == RAMP_RUN |=>
      ($changed(clk_o.coarse) -> (clk_o.coarse - $past(clk_o.coarse)
        == 8'h01 || $past(clk_o.coarse) - clk_o.coarse == 8'h01)))
    else $error("ramp moved more than one step");

  a_ramp_slow_rate: assert property (
    st_reg.ramp == RAMP_RUN && st_reg.ramp_en && !st_reg.ramp_fast &&
    !wr_delay && st_reg.eff != st_reg.target && !ramp_step
    |=> $stable(clk_o.coarse))
    else $error("slow ramp stepped early");

  a_ramp_fast_step: assert property (
    st_reg.ramp == RAMP_RUN && st_reg.ramp_en && st_reg.ramp_fast &&
    !wr_delay && st_reg.eff != st_reg.target &&
    st_reg.ramp_cnt == `RAMP_FAST_PERIOD |=> $changed(clk_o.coarse))
    else $error("fast ramp missed its step");

  a_ramp_ends: assert property (
    st_reg.ramp == RAMP_RUN && st_reg.eff == st_reg.target && !wr_delay
    |=> st_reg.ramp == RAMP_IDLE)
    else $error("ramp did not end at target");

  a_map_ends_set: assert property (
    st_reg.map[0] && st_reg.map[23])
    else $error("end positions not flagged");

  a_map_sticky: assert property (
    |($past(st_reg.map) & ~st_reg.map) |-> $past(wr_map))
    else $error("map bit dropped without clear");

  a_valid_edges: assert property (
    $rose(st_reg.edge_cnt == `EDGES_NEEDED) |->
      $past(st_reg.sync2[`POS_MID]) && !$past(st_reg.prev_mid))
    else $error("valid without a third edge");

  a_capture_sel: assert property (
    ##1 clk_o.sref_captured == $past(st_reg.sync2[st_reg.sel]))
    else $error("capture not at selected position");

  // Register writes land one clock after the data phase
  a_fine_write: assert property (
    wr_delay |=> clk_o.fine == $past(ahb_i.hwdata[`F_FINE_HI:`F_FINE_LO]))
    else $error("fine delay did not follow write");

  a_sel_write: assert property (
    wr_sref |=> st_reg.sel == $past(ahb_i.hwdata[`F_SEL_HI:`F_SEL_LO]))
    else $error("select did not follow write");

  a_refine_write: assert property (
    wr_sref |=> clk_o.refine == $past(ahb_i.hwdata[`F_REFINE]))
    else $error("refine did not follow write");

  a_dual_edge_write: assert property (
    wr_sref |=> clk_o.dual_edge == $past(ahb_i.hwdata[`F_SINGLE_CH]))
    else $error("dual edge did not follow write");

  // Settings hold between writes, so nothing drifts on its own
  a_invert_hold: assert property (
    !wr_delay |=> $stable(clk_o.invert))
    else $error("inversion moved without write");

  a_fine_hold: assert property (
    !wr_delay |=> $stable(clk_o.fine))
    else $error("fine delay moved without write");

  a_sel_hold: assert property (
    !wr_sref |=> $stable(st_reg.sel))
    else $error("select moved without write");

  a_target_hold: assert property (
    !wr_delay |=> $stable(st_reg.target))
    else $error("coarse target moved without write");

  // Ramp bypass, idle behaviour and fast-ramp rest between steps
  a_idle_no_move: assert property (
    st_reg.ramp == RAMP_IDLE && !wr_delay |=>
      clk_o.coarse == $past(st_reg.target))
    else $error("idle coarse left the target");

  a_ramp_off_jump: assert property (
    st_reg.ramp == RAMP_RUN && !st_reg.ramp_en && !wr_delay |=>
      clk_o.coarse == $past(st_reg.target))
    else $error("disabled ramp did not jump to target");

  a_ramp_fast_rest: assert property (
    st_reg.ramp == RAMP_RUN && st_reg.ramp_en && st_reg.ramp_fast &&
    !wr_delay && st_reg.eff != st_reg.target && !ramp_step
    |=> $stable(clk_o.coarse))
    else $error("fast ramp stepped early");

  // Position map and edge count upkeep
  a_map_clear: assert property (
    wr_map |=> st_reg.map == ($past(viol) | `POS_ENDS))
    else $error("map clear lost ends or new flags");

  a_map_gathers: assert property (
    !wr_map |=> (st_reg.map & $past(viol)) == $past(viol))
    else $error("map missed a violation flag");

  a_edge_clear: assert property (
    wr_map |=> st_reg.edge_cnt == 2'h0)
    else $error("edge count not cleared with map");

  a_edge_hold: assert property (
    st_reg.edge_cnt == `EDGES_NEEDED && !wr_map |=>
      st_reg.edge_cnt == `EDGES_NEEDED)
    else $error("valid edge count dropped");

  // Read data stands only in the data phase of a read
  a_hrdata_idle: assert property (
    !(addr_take && !ahb_i.hwrite) |=> ahb_o.hrdata == `RST_WORD)
    else $error("read data outside a read");

  a_hrdata_map: assert property (
    addr_take && !ahb_i.hwrite && hit(ahb_i.haddr[3:0], `OFS_POS_MAP)
    |=> ahb_o.hrdata[23:0] == $past(st_reg.map))
    else $error("map read returned wrong data");

endmodule

`default_nettype wire

// [dv/sref_source.sv]
`timescale 1ns/1ps
`default_nettype none

module sref_source (
  // Clock and pulse request
  input wire logic clk,
  input wire logic launch,
  input wire logic [4:0] edge_pos,
  // Reference seen through the delayed position taps
  output var logic [23:0] taps = 24'h000000
);
  int ph = -1;

  // One pulse: the edge falls inside the taps, then high, then low
  always @(posedge clk) begin
    if (launch && ph < 0) ph <= 0;
    else if (ph >= 0 && ph < 11) ph <= ph + 1;
    else ph <= -1;
    if (ph >= 0 && ph < 4) taps <= (24'h000001 << edge_pos) - 24'h000001;
    else if (ph >= 4 && ph < 8) taps <= 24'hffffff;
    else taps <= 24'h000000;
  end
endmodule

`default_nettype wire

// [dv/tb_sampling_delay_and_sysref_window.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sref_delay_map.svh"

module tb_sampling_delay_and_sysref_window
  import sref_delay_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic launch = 1'b0;
  logic [4:0] edge_pos = 5'h01;
  logic [23:0] taps;
  ahb_req_t req = '0;
  ahb_req_t bus_in;
  ahb_rsp_t ahb_o;
  clk_ctrl_t clk_o;
  int n_mismatch = 0;
  int checks_done = 0;
  int eff_m = 0;
  int sel_m = 0;
  int map_m = 'h800001;
  int k;
  logic [23:0] hist[$];
  bit cap_chk = 0;
  logic [31:0] rd;

  // Clock; bus ready is the slave's own ready
  always #5 clk = ~clk;
  always_comb begin
    bus_in = req;
    bus_in.hready = ahb_o.hreadyout;
  end

  sampling_delay_and_sysref_window u_sampling_delay_and_sysref_window (
    .clk(clk), .sys_rst(sys_rst), .ahb_i(bus_in), .ahb_o(ahb_o),
    .sref_taps(taps), .clk_o(clk_o));
  sref_source u_sref_source (
    .clk(clk), .launch(launch), .edge_pos(edge_pos), .taps(taps));

  task results;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ahb_o.hreadyout !== 1'b1 && n < 20);
    if (ahb_o.hreadyout !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t bus timeout", $time);
      results();
    end
  endtask

  // Single word transfer: address phase, then data phase
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req.hsel <= 1'b1;
    req.haddr <= {28'h0, a};
    req.htrans <= 2'b10;
    req.hwrite <= w;
    req.hsize <= 3'b010;
    wait_rdy();
    req.htrans <= 2'b00;
    req.hwdata <= d;
    wait_rdy();
    rd = ahb_o.hrdata;
    #1;
  endtask

  task rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  function automatic logic [31:0] dctl(int c, int f, int en, int fast);
    return 32'(c << `F_COARSE_LO | f << `F_FINE_LO | en << `F_RAMP_EN
      | fast << `F_RAMP_FAST);
  endfunction

  // Follow a ramp: unit steps, spaced by the rate's period
  task ramp_watch(input int tgt, input int per);
    int n, last;
    n = 0;
    last = -1;
    while (clk_o.coarse !== 8'(tgt) && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
      if (clk_o.coarse !== 8'(eff_m)) begin
        eff_m = (tgt > eff_m) ? eff_m + 1 : eff_m - 1;
        check({24'h0, clk_o.coarse}, 32'(eff_m));
        if (last >= 0) check(32'(n - last), 32'(per));
        last = n;
      end
    end
    check({24'h0, clk_o.coarse}, 32'(tgt));
    if (n >= 3000) results();
  endtask

  task launch_ref(input int p);
    @(posedge clk);
    launch <= 1'b1;
    edge_pos <= 5'(p);
    @(posedge clk);
    launch <= 1'b0;
    repeat (16) @(posedge clk);
    #1;
  endtask

  // Selected tap must reach the capture output three clocks later
  always @(posedge clk) begin
    hist.push_back(taps);
    if (hist.size() > 4) void'(hist.pop_front());
    if (cap_chk && hist.size() == 4)
      check({31'h0, clk_o.sref_captured}, {31'h0, hist[0][sel_m]});
  end

  // Main sequence
  initial begin
    void'($urandom(44387));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check({12'h0, clk_o}, 32'h0);
    rchk(`OFS_DELAY_CTRL, 32'h0);
    rchk(`OFS_SREF_CTRL, 32'h0);
    rchk(`OFS_POS_MAP, 32'h00800001);
    bus(1'b1, `OFS_STATUS, 32'hffffffff);
    rchk(`OFS_STATUS, 32'h0);
    k = $urandom_range(255);
    bus(1'b1, `OFS_DELAY_CTRL, dctl(255, k, 0, 0) | 32'h1);
    check({11'h0, clk_o.invert, clk_o.coarse, clk_o.fine},
      32'('h1ff00 | k));
    rchk(`OFS_DELAY_CTRL, dctl(255, k, 0, 0) | 32'h1);
    bus(1'b1, `OFS_DELAY_CTRL, dctl(0, k, 0, 0));
    eff_m = 0;
    bus(1'b1, `OFS_DELAY_CTRL, dctl(3, k, 1, 1));
    bus(1'b0, `OFS_STATUS, 32'h0);
    check({31'h0, rd[`F_STAT_RAMPING]}, 32'h1);
    ramp_watch(3, 96);
    bus(1'b1, `OFS_DELAY_CTRL, dctl(1, k, 1, 0));
    ramp_watch(1, 256);
    bus(1'b1, `OFS_DELAY_CTRL, dctl(5, k, 1, 0));
    repeat (300) @(posedge clk);
    eff_m = 2;
    bus(1'b1, `OFS_DELAY_CTRL, dctl(0, k, 1, 1));
    ramp_watch(0, 96);
    bus(1'b1, `OFS_DELAY_CTRL, dctl(9, k, 1, 1));
    repeat (20) @(posedge clk);
    bus(1'b1, `OFS_DELAY_CTRL, dctl(6, k, 0, 0));
    check({24'h0, clk_o.coarse}, 32'h6);
    rchk(`OFS_STATUS, 32'h6);
    k = $urandom_range(22, 1);
    launch_ref(k);
    launch_ref(k);
    rchk(`OFS_STATUS, 32'h6);
    launch_ref(k);
    rchk(`OFS_STATUS, 32'h206);
    map_m = map_m | (3 << (k - 1));
    rchk(`OFS_POS_MAP, 32'(map_m));
    bus(1'b1, `OFS_POS_MAP, 32'h0);
    rchk(`OFS_POS_MAP, 32'h00800001);
    rchk(`OFS_STATUS, 32'h6);
    for (int i = 0; i < 3; i++) begin
      sel_m = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(14, 1);
      bus(1'b1, `OFS_SREF_CTRL, 32'(sel_m | i << `F_REFINE));
      check({30'h0, clk_o.dual_edge, clk_o.refine}, 32'(i));
      cap_chk = 1;
      launch_ref(sel_m + 1);
      cap_chk = 0;
    end
    results();
  end
endmodule

`default_nettype wire
